// ===== inc/ism_pkg.sv
// Constants and helpers for the interrupt source map.
// Assumes a single system clock; no software-visible registers.
package ism_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int unsigned NUM_SRC = 20;    // Vectored peripheral sources
   localparam int unsigned ID_W = 5;        // Source ID width
   localparam int unsigned EXC_W = 6;       // Exception number width
   localparam int unsigned VEC_W = 8;       // Vector byte offset width
   localparam int unsigned PRIO_W = 4;      // Priority field width
   localparam int unsigned NUM_PRIO = 16;   // Programmable priority levels
   localparam int unsigned FLAG_W = 8;      // Internal flags per peripheral
   localparam int unsigned WAKE_OPT_W = 3;  // Optional wake source enables

   // ---------------------------------------------------------------
   // Numbering
   // ---------------------------------------------------------------
   localparam logic [EXC_W-1:0] EXC_BASE = 6'h10;      // First peripheral exception
   localparam logic [ID_W-1:0] ID_MAX = 5'h13;         // Highest source ID
   localparam logic [PRIO_W-1:0] PRIO_LOWEST = 4'hF;   // Idle priority value

   // ---------------------------------------------------------------
   // Source IDs
   // ---------------------------------------------------------------
   localparam logic [ID_W-1:0] SRC_PULSE_CH1 = 5'h00;  // Pulse generator ch1
   localparam logic [ID_W-1:0] SRC_PULSE_CH6 = 5'h05;  // Pulse generator ch6
   localparam logic [ID_W-1:0] SRC_SYS_CTRL = 5'h06;   // System controller
   localparam logic [ID_W-1:0] SRC_MAC = 5'h07;        // MAC
   localparam logic [ID_W-1:0] SRC_AES = 5'h08;        // AES codec
   localparam logic [ID_W-1:0] SRC_PHY = 5'h09;        // PHY controller
   localparam logic [ID_W-1:0] SRC_SERIAL_A = 5'h0A;   // Serial port a
   localparam logic [ID_W-1:0] SRC_SERIAL_B = 5'h0B;   // Serial port b
   localparam logic [ID_W-1:0] SRC_SPI_SLV = 5'h0C;    // SPI slave
   localparam logic [ID_W-1:0] SRC_SPI_MST = 5'h0D;    // SPI master
   localparam logic [ID_W-1:0] SRC_I2C = 5'h0E;        // I2C master/slave
   localparam logic [ID_W-1:0] SRC_TIMER_A = 5'h0F;    // General timer a
   localparam logic [ID_W-1:0] SRC_TIMER_B = 5'h10;    // General timer b
   localparam logic [ID_W-1:0] SRC_TIMER_ADC = 5'h11;  // Timer ADC
   localparam logic [ID_W-1:0] SRC_ANALOG = 5'h12;     // Analog peripheral
   localparam logic [ID_W-1:0] SRC_WATCHDOG = 5'h13;   // Watchdog

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Exception number of a source ID
   function automatic logic [EXC_W-1:0] ism_exc_of(input logic [ID_W-1:0] id);
      ism_exc_of = EXC_BASE + {1'b0, id};
   endfunction

   // Vector table byte offset of an exception number
   function automatic logic [VEC_W-1:0] ism_vec_of(input logic [EXC_W-1:0] exc);
      ism_vec_of = {exc, 2'b00};
   endfunction

endpackage : ism_pkg

// ===== core/ism_prio_pick.sv
// Combinational pick of the most urgent pending source.
// Assumes requests and priorities are stable in the system clock domain.
module ism_prio_pick
   import ism_pkg::*;
(
   input wire logic [NUM_SRC-1:0] req_i,             // Pending request lines
   input wire logic [NUM_SRC-1:0][PRIO_W-1:0] prio_i, // Per-source priority
   output logic valid_o,                             // Any source pending
   output logic [ID_W-1:0] id_o,                     // Winning source ID
   output logic [PRIO_W-1:0] prio_o                  // Winning priority
);

   // ----------------------------------------------------------------
   // Search
   // ----------------------------------------------------------------
   // Lower value is more urgent; on a tie the lower ID wins, so scan
   // upward and replace only on a strictly better value.
   always_comb begin
      valid_o = 1'b0;
      id_o = '0;
      prio_o = PRIO_LOWEST;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (req_i[i] && (!valid_o || prio_i[i] < prio_o)) begin
            valid_o = 1'b1;
            id_o = ID_W'(i);
            prio_o = prio_i[i];
         end
      end
   end

endmodule // ism_prio_pick

// ===== core/ism_source_map.sv
// Interrupt source map: merges peripheral flags onto one request line
// per source, tracks software-raised interrupts, and presents the most
// urgent source with its exception number and vector offset.
// Assumes all peripheral inputs come from logic on sys_clk_i.
//
// Operation
// - One request line per peripheral, flags merged
// - Exception number equals source ID plus 16
// - Vector offset is four times exception number
// - Software raises interrupts by ID 0 to 19
// - IDs 0-5 pulse channels, 6-9 system blocks
// - IDs 10-19 serial, SPI, I2C, timers, analog, watchdog
// - Twenty vectored peripheral sources in total
// - Sixteen priority levels per source
// - In sleep only wake sources stay alive
module ism_source_map
   import ism_pkg::*;
(
   input wire logic sys_clk_i,                               // System clock
   input wire logic rst_b_i,                                 // Async reset, low
   input wire logic [NUM_SRC-1:0][FLAG_W-1:0] periph_flag_i,    // Peripheral flags
   input wire logic [NUM_SRC-1:0][FLAG_W-1:0] periph_flag_en_i, // Flag enables
   input wire logic [NUM_SRC-1:0][PRIO_W-1:0] prio_i,        // Source priorities
   input wire logic sw_set_i,                                // Software raise pulse
   input wire logic [ID_W-1:0] sw_set_id_i,                  // ID to raise
   input wire logic sw_clr_i,                                // Software clear pulse
   input wire logic [ID_W-1:0] sw_clr_id_i,                  // ID to clear
   input wire logic sleep_i,                                 // Sleep or deep sleep
   input wire logic digital_pin_irq_i,                       // Digital pin event
   input wire logic pulse_cnt_irq_i,                         // Pulse counter event
   input wire logic wake_timer_irq_i,                        // Wake-up timer event
   input wire logic comparator_irq_i,                        // Analog comparator event
   input wire logic [WAKE_OPT_W-1:0] wake_opt_en_i,          // Optional wake enables
   output logic [NUM_SRC-1:0] irq_req_o,                     // Lines to nested_vector_irq_ctrl
   output logic pend_valid_o,                                // A source is pending
   output logic [ID_W-1:0] pend_id_o,                        // Pending source ID
   output logic [EXC_W-1:0] pend_exc_o,                      // Its exception number
   output logic [VEC_W-1:0] pend_vec_o,                      // Its vector byte offset
   output logic [PRIO_W-1:0] pend_prio_o,                    // Its priority
   output logic wake_o                                       // Wake request in sleep
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [NUM_SRC-1:0] merged; // Per-source OR of enabled flags
   logic [NUM_SRC-1:0] sw_pend_q; // Software-raised pending bits
   logic [NUM_SRC-1:0] irq_req_q; // Registered request lines
   logic [NUM_SRC-1:0] irq_req_d; // Next request lines
   logic pick_valid; // Selector found a source
   logic [ID_W-1:0] pick_id; // Selector winner
   logic [PRIO_W-1:0] pick_prio; // Selector winner priority
   logic pend_valid_q; // Registered pending flag
   logic [ID_W-1:0] pend_id_q; // Registered pending ID
   logic [EXC_W-1:0] pend_exc_q; // Registered exception number
   logic [VEC_W-1:0] pend_vec_q; // Registered vector offset
   logic [PRIO_W-1:0] pend_prio_q; // Registered priority
   logic wake_q; // Registered wake request
   logic wake_d; // Next wake request

   // ----------------------------------------------------------------
   // Flag merge
   // ----------------------------------------------------------------
   // Each peripheral's enabled flags collapse to one line, so a source
   // keeps requesting until software has cleared every enabled flag.
   always_comb begin
      for (int i = 0; i < NUM_SRC; i++) begin
         merged[i] = |(periph_flag_i[i] & periph_flag_en_i[i]);
      end
   end

   // ----------------------------------------------------------------
   // Software-raised pending bits
   // ----------------------------------------------------------------
   // Indexed by interrupt number; IDs past the last source are ignored.
   // A set in the same cycle as a clear of that bit wins.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sw_pend_q <= '0;
      end else begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (sw_set_i && sw_set_id_i == ID_W'(i) && sw_set_id_i <= ID_MAX) begin
               sw_pend_q[i] <= 1'b1;
            end else if (sw_clr_i && sw_clr_id_i == ID_W'(i)) begin
               sw_pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Request lines
   // ----------------------------------------------------------------
   // Bit position equals source ID; the controller is unpowered in
   // sleep, so every line drops while sleep_i is high.
   always_comb begin
      if (sleep_i) begin
         irq_req_d = '0;
      end else begin
         irq_req_d = merged | sw_pend_q;
      end
   end

   // Register the lines so the core sees glitch-free levels
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_req_q <= '0;
      end else begin
         irq_req_q <= irq_req_d;
      end
   end

   // ----------------------------------------------------------------
   // Priority selection
   // ----------------------------------------------------------------
   ism_prio_pick u_pick (
      .req_i(irq_req_q),
      .prio_i(prio_i),
      .valid_o(pick_valid),
      .id_o(pick_id),
      .prio_o(pick_prio)
   );

   // Register the winner together with its exception and vector slot
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend_valid_q <= 1'b0;
         pend_id_q <= '0;
         pend_exc_q <= '0;
         pend_vec_q <= '0;
         pend_prio_q <= PRIO_LOWEST;
      end else if (sleep_i || !pick_valid) begin
         // Nothing to present
         pend_valid_q <= 1'b0;
         pend_id_q <= '0;
         pend_exc_q <= '0;
         pend_vec_q <= '0;
         pend_prio_q <= PRIO_LOWEST;
      end else begin
         pend_valid_q <= 1'b1;
         pend_id_q <= pick_id;
         pend_prio_q <= pick_prio;
         pend_exc_q <= ism_exc_of(pick_id);
         pend_vec_q <= ism_vec_of(ism_exc_of(pick_id));
      end
   end

   // ----------------------------------------------------------------
   // Wake logic
   // ----------------------------------------------------------------
   // Digital pin events always wake; the other three only if enabled.
   always_comb begin
      wake_d = sleep_i && (digital_pin_irq_i
         || (wake_opt_en_i[0] && pulse_cnt_irq_i)
         || (wake_opt_en_i[1] && wake_timer_irq_i)
         || (wake_opt_en_i[2] && comparator_irq_i));
   end

   // Register the wake request
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign irq_req_o = irq_req_q;
   assign pend_valid_o = pend_valid_q;
   assign pend_id_o = pend_id_q;
   assign pend_exc_o = pend_exc_q;
   assign pend_vec_o = pend_vec_q;
   assign pend_prio_o = pend_prio_q;
   assign wake_o = wake_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   merge_flag_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (!sleep_i && |(periph_flag_i[SRC_PULSE_CH1] & periph_flag_en_i[SRC_PULSE_CH1]))
      |=> irq_req_o[SRC_PULSE_CH1])
      else $error("merged flag did not raise its line");

   exc_number_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      pend_valid_o |-> (pend_exc_o == pend_id_o + 6'h10) && pend_exc_o <= 6'h23)
      else $error("exception number not ID plus 16");

   vec_offset_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      pend_valid_o |-> pend_vec_o == 8'(pend_exc_o * 4) && pend_vec_o <= 8'h8C)
      else $error("vector offset not four times exception");

   sw_raise_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (sw_set_i && sw_set_id_i == SRC_WATCHDOG && !sleep_i && !$past(sleep_i))
      ##1 !sleep_i |=> irq_req_o[SRC_WATCHDOG])
      else $error("software raise did not reach its line");

   phy_slot_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (!sleep_i && |(periph_flag_i[SRC_PHY] & periph_flag_en_i[SRC_PHY]))
      |=> irq_req_o[9])
      else $error("PHY flag not on line 9");

   serial_slot_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (!sleep_i && |(periph_flag_i[SRC_SERIAL_B] & periph_flag_en_i[SRC_SERIAL_B]))
      |=> irq_req_o[11])
      else $error("serial port b flag not on line 11");

   src_range_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      pend_valid_o |-> pend_id_o < 5'd20 && $past(irq_req_o) != '0)
      else $error("pending ID outside the twenty sources");

   prio_win_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (irq_req_o[0] && prio_i[0] == 4'h0 && !sleep_i)
      |=> pend_valid_o && pend_id_o == 5'h00 && pend_prio_o == 4'h0)
      else $error("most urgent source not presented");

   sleep_gate_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      sleep_i |=> irq_req_o == '0 && !pend_valid_o && wake_o == $past(wake_d))
      else $error("lines active during sleep");

   // A digital pin event must wake the device whatever the options say
   pin_wake_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (sleep_i && digital_pin_irq_i) |=> wake_o)
      else $error("digital pin event did not wake");

   // No wake request is raised while the device is awake
   awake_quiet_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      !sleep_i |=> !wake_o)
      else $error("wake raised while awake");

   level_drop_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (!sleep_i && !merged[SRC_MAC] && !sw_pend_q[SRC_MAC]) |=> !irq_req_o[SRC_MAC])
      else $error("line stayed high after flags cleared");

endmodule // ism_source_map

// ===== sim/ism_core_model.sv
// ---------------------------------------------------------------
// Behavioural model of the processor-side interrupt controller
// ---------------------------------------------------------------
// Assumes the bench drives its command inputs just after sys_clk_i rises.
module ism_core_model
   import ism_pkg::*;
(
   input wire logic sys_clk_i,               // System clock
   input wire logic rst_b_i,                 // Async reset, low
   input wire logic cmd_set_i,               // Bench asks for a raise
   input wire logic [ID_W-1:0] cmd_set_id_i, // Interrupt number to raise
   input wire logic cmd_clr_i,               // Bench asks for a clear
   input wire logic [ID_W-1:0] cmd_clr_id_i, // Interrupt number to clear
   output logic sw_set_o,                    // Raise pulse to the map
   output logic [ID_W-1:0] sw_set_id_o,      // Raised interrupt number
   output logic sw_clr_o,                    // Clear pulse to the map
   output logic [ID_W-1:0] sw_clr_id_o       // Cleared interrupt number
);
   timeunit 1ns;
   timeprecision 1ps;

   // Raise pulse, numbered by interrupt number, never exception number
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sw_set_o <= 1'b0;
         sw_set_id_o <= 5'h00;
      end else begin
         sw_set_o <= cmd_set_i;
         // Idle number lines invert each cycle, so the last number returns every other cycle
         sw_set_id_o <= cmd_set_i ? cmd_set_id_i : ~sw_set_id_o;
      end
   end

   // Clear pulse, same numbering and same idle behaviour
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sw_clr_o <= 1'b0;
         sw_clr_id_o <= 5'h00;
      end else begin
         sw_clr_o <= cmd_clr_i;
         sw_clr_id_o <= cmd_clr_i ? cmd_clr_id_i : ~sw_clr_id_o;
      end
   end
endmodule // ism_core_model

// ===== sim/ism_source_map_test.sv
// ---------------------------------------------------------------
// Self-checking bench for the interrupt source map
// ---------------------------------------------------------------
// Assumes ism_pkg is compiled first and the core model stands beside it.
module ism_source_map_test
   import ism_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk_i = 1'b0; // Bench clock
   logic rst_b_i; // Bench reset
   logic [NUM_SRC-1:0][FLAG_W-1:0] flag, flag_en; // Peripheral flags
   logic [NUM_SRC-1:0][PRIO_W-1:0] prio; // Priorities
   logic sleep, pin_irq, cnt_irq, tmr_irq, cmp_irq; // Power and wake
   logic [WAKE_OPT_W-1:0] opt_en; // Optional wake enables
   logic cmd_set, cmd_clr, sw_set, sw_clr; // Software raise and clear
   logic [ID_W-1:0] cmd_set_id, cmd_clr_id, sw_set_id, sw_clr_id; // Numbers
   logic [NUM_SRC-1:0] irq_req; // Request lines
   logic pend_valid, wake; // Pending and wake
   logic [ID_W-1:0] pend_id; // Pending source
   logic [EXC_W-1:0] pend_exc; // Pending exception
   logic [VEC_W-1:0] pend_vec; // Pending vector offset
   logic [PRIO_W-1:0] pend_prio; // Pending priority
   int miscompares = 0, checks_done = 0, cycles = 0; // Counters

   always #10 sys_clk_i = ~sys_clk_i;

   ism_source_map ism_source_map_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .periph_flag_i(flag), .periph_flag_en_i(flag_en), .prio_i(prio),
      .sw_set_i(sw_set), .sw_set_id_i(sw_set_id), .sw_clr_i(sw_clr),
      .sw_clr_id_i(sw_clr_id), .sleep_i(sleep), .digital_pin_irq_i(pin_irq),
      .pulse_cnt_irq_i(cnt_irq), .wake_timer_irq_i(tmr_irq),
      .comparator_irq_i(cmp_irq), .wake_opt_en_i(opt_en), .irq_req_o(irq_req),
      .pend_valid_o(pend_valid), .pend_id_o(pend_id), .pend_exc_o(pend_exc),
      .pend_vec_o(pend_vec), .pend_prio_o(pend_prio), .wake_o(wake));

   ism_core_model ism_core_model_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .cmd_set_i(cmd_set), .cmd_set_id_i(cmd_set_id), .cmd_clr_i(cmd_clr),
      .cmd_clr_id_i(cmd_clr_id), .sw_set_o(sw_set), .sw_set_id_o(sw_set_id),
      .sw_clr_o(sw_clr), .sw_clr_id_o(sw_clr_id));

   // Expected lines: any enabled flag of a source raises its line
   function automatic logic [NUM_SRC-1:0] exp_lines();
      for (int i = 0; i < NUM_SRC; i++) exp_lines[i] = |(flag[i] & flag_en[i]);
   endfunction

   // Expected winner: lowest priority value, ties to the lowest ID
   function automatic logic [ID_W-1:0] exp_pick(input logic [NUM_SRC-1:0] l);
      logic [PRIO_W:0] best;
      best = 5'h10;
      exp_pick = 5'h00;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (l[i] && {1'b0, prio[i]} < best) begin
            best = {1'b0, prio[i]};
            exp_pick = ID_W'(i);
         end
      end
   endfunction

   // One comparison, counted and reported at once
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Move past n rising edges, then settle off the edge
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #2;
   endtask

   // Pending outputs against the expected winner
   task automatic check_pend(input logic [NUM_SRC-1:0] l);
      logic [ID_W-1:0] w;
      w = exp_pick(l);
      check(pend_valid, |l, "pend valid");
      if (|l) begin
         check(pend_id, w, "pend id");
         check(pend_exc, 32'(w) + 32'h0000_0010, "exception");
         check(pend_vec, (32'(w) + 32'h0000_0010) * 32'h0000_0004, "vector");
         check(pend_prio, prio[w], "priority");
      end
   endtask

   // Software raise or clear through the core model
   task automatic sw_cmd(input logic s, input logic [ID_W-1:0] sid, input logic c,
                         input logic [ID_W-1:0] cid);
      cmd_set = s;
      cmd_set_id = sid;
      cmd_clr = c;
      cmd_clr_id = cid;
      step(1);
      cmd_set = 1'b0;
      cmd_clr = 1'b0;
      step(4);
   endtask

   // Report counts and verdict, then stop
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end

   // Main sequence
   initial begin
      logic [NUM_SRC-1:0] l;
      int b;
      void'($urandom(24251));
      {flag, flag_en, prio} = '0;
      {sleep, pin_irq, cnt_irq, tmr_irq, cmp_irq, opt_en} = '0;
      {cmd_set, cmd_clr, cmd_set_id, cmd_clr_id} = '0;
      rst_b_i = 1'b0;
      step(2);
      check({irq_req, pend_valid, pend_prio, wake}, 26'h000_001E, "reset values");
      rst_b_i = 1'b1;
      // Each source alone: disabled flag, enabled flag, then cleared flag
      for (int s = 0; s < NUM_SRC; s++) begin
         flag = '0;
         b = $urandom_range(7, 0);
         flag[s][b] = 1'b1;
         flag_en[s] = ~flag[s];
         step(2);
         check(irq_req, 32'h0000_0000, "masked flag");
         flag_en[s] = flag[s] | FLAG_W'($urandom);
         step(2);
         check(irq_req, 32'h0000_0001 << s, "single line");
         check_pend(exp_lines());
         flag[s] = 8'h00;
         step(1);
         check(irq_req, 32'h0000_0000, "line drops");
      end
      // Random mixes, with all-on ties and a lone urgent top source first
      for (int n = 0; n < 40; n++) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            flag[i] = n < 2 ? 8'hFF : FLAG_W'($urandom);
            flag_en[i] = (n < 2 || $urandom_range(2, 0) == 0) ? FLAG_W'($urandom) | 8'h01 : 8'h00;
            prio[i] = n < 2 ? 4'hF : PRIO_W'($urandom);
         end
         if (n == 1)
            prio[19] = 4'h0;
         step(2);
         l = exp_lines();
         check(irq_req, l, "merged lines");
         check_pend(l);
      end
      // Software raise and clear by interrupt number
      flag = '0;
      sw_cmd(1'b1, ID_MAX, 1'b0, 5'h00);
      check(irq_req, 32'h0008_0000, "sw raise top");
      sw_cmd(1'b1, 5'h14, 1'b0, 5'h00);
      check(irq_req, 32'h0008_0000, "sw raise out of range");
      sw_cmd(1'b1, 5'h03, 1'b1, 5'h03);
      check(irq_req, 32'h0008_0008, "set beats clear");
      check_pend(20'h8_0008);
      sw_cmd(1'b0, 5'h00, 1'b1, ID_MAX);
      check(irq_req, 32'h0000_0008, "sw clear");
      sw_cmd(1'b0, 5'h00, 1'b1, 5'h03);
      check(irq_req, 32'h0000_0000, "sw clear all");
      // Sleep blanks lines; only wake sources act, optional ones gated
      flag = '1;
      flag_en = '1;
      sleep = 1'b1;
      step(2);
      check({irq_req, pend_valid, wake}, 32'h0000_0000, "sleep blanks");
      for (int k = 0; k < 4; k++) begin
         {cmp_irq, tmr_irq, cnt_irq, pin_irq} = 4'h1 << k;
         opt_en = (k == 0) ? 3'h0 : ~(3'h1 << (k - 1));
         step(1);
         check(wake, k == 0, "wake gating");
         opt_en = 3'h7;
         step(1);
         check(wake, 32'h0000_0001, "wake source");
      end
      sleep = 1'b0;
      step(2);
      check({irq_req, wake}, 32'h001F_FFFE, "awake again");
      give_verdict();
   end
endmodule // ism_source_map_test
